// ---- rtl/gedh_cfg.svh ----
`ifndef GEDH_CFG_SVH
`define GEDH_CFG_SVH

// Register word indices; byte address is four times the index
`define GEDH_IDX_NUM1 10'h12C
`define GEDH_IDX_DEN 10'h12D
`define GEDH_IDX_ENC_OUT 10'h12E
`define GEDH_IDX_HOME_MODE 10'h12F
`define GEDH_IDX_FAST_SPD 10'h130
`define GEDH_IDX_SLOW_SPD 10'h131
`define GEDH_IDX_OFS_REV 10'h132
`define GEDH_IDX_OFS_PULSE 10'h133
`define GEDH_IDX_NUM2 10'h140
`define GEDH_IDX_NUM3 10'h141
`define GEDH_IDX_NUM4 10'h142
`define GEDH_IDX_SCALE_SHIFT 10'h143
`define GEDH_IDX_STATUS 10'h144

// Reset values
`define GEDH_RST_NUM 16'h0001
`define GEDH_RST_DEN 16'h0001
`define GEDH_RST_ENC_OUT 16'h0001
`define GEDH_RST_HOME_MODE 16'h0000
`define GEDH_RST_FAST_SPD 16'h03E8
`define GEDH_RST_SLOW_SPD 16'h0032
`define GEDH_RST_OFS 16'h0000
`define GEDH_RST_SHIFT 16'h0007

// Encoder output scaling
`define GEDH_ENC_LINES 32'd2500
`define GEDH_ENC_DIRECT_BASE 16'd10000
`define GEDH_ENC_SCALE_NUM 32'd128
`define GEDH_OFS_PER_REV 32'sd10000

// Emulated output rate limit: 500 kpps is one pulse per 2000 ns
`define GEDH_CLK_MHZ 20
`define GEDH_ENC_MIN_PERIOD_NS 2000
`define GEDH_ENC_MIN_CYC \
  ((`GEDH_ENC_MIN_PERIOD_NS * `GEDH_CLK_MHZ + 999) / 1000)

`endif

// ---- rtl/gedh_pkg.sv ----
`default_nettype none

package gedh_pkg;
  // Gray codes along search, approach, return, offset, done
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_FAST = 3'h1,
    ST_ZSEEK = 3'h3,
    ST_RETURN = 3'h2,
    ST_OFFSET = 3'h6,
    ST_DONE = 3'h7
  } gedh_state_t;
endpackage

`default_nettype wire

// ---- rtl/gedh_top.sv ----
// Functional notes
// - Mode digit zero emits 2500 divided by the low field per revolution.
// - Mode digit one emits the low field value per revolution.
// - Mode digit sits in ten-thousands; direct settings are 10020 to 12500.
// - Output count is further scaled by 2^7 over 2^shift, shift default 7.
// - Emulated encoder output never exceeds 500 kpps.
// - Search digit picks reference and direction: limits, origin, Z marker.
// - Z digit: reverse to Z, forward to Z, or stop at reference.
// - Trigger digit: off, automatic after power-up, or on start input.
// - Stop digit: return to home point, or stop in forward direction.
// - After origin found with Z digit zero, reverse at slow speed to the nearest Z marker.
// - Reference search runs at the fast homing speed.
// - Final approach runs at the slow homing speed.
// - Revolution offset is signed, within plus or minus 30000.
// - Home lies at reference plus revolutions times 10000 plus pulses.
`include "gedh_cfg.svh"
`timescale 1ns/1ps
`default_nettype none

module gedh_top #(
  parameter int ACC_W = 34,
  parameter int PEND_W = 8
) (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic [11:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  input wire logic i_cmd_pulse,
  input wire logic i_cmd_fwd,
  input wire logic [1:0] i_gear_sel,
  output logic o_pos_step,
  output logic o_pos_fwd,
  input wire logic i_enc_pulse,
  output logic o_enc_out_pulse,
  input wire logic i_fwd_limit,
  input wire logic i_rev_limit,
  input wire logic i_origin,
  input wire logic i_zmark,
  input wire logic i_start_homing,
  input wire logic i_fb_pulse,
  output logic o_home_move,
  output logic o_home_fwd,
  output logic [15:0] o_home_speed,
  output logic o_home_done
);

  ////////////////////////////////////////////////////////////////////////////
  logic [15:0] num_ff [4];
  logic [15:0] den_ff, enc_set_ff, hmode_ff, fast_ff, slow_ff;
  logic [15:0] ofs_rev_ff, ofs_pls_ff, shift_ff;
  gedh_pkg::gedh_state_t state_ff, nxt_state;
  logic mode_bad;
  logic [9:0] idx;
  logic req, acc_edge;
  logic [15:0] wmask, rd16;

  assign idx = i_avs_address[11:2];
  assign req = i_avs_read | i_avs_write;
  // Every request waits one cycle, then completes
  assign acc_edge = req & ~o_avs_waitrequest;
  assign wmask = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};

  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [31:0] wd,
                                        input logic [15:0] m);
    merge = (old & ~m) | (wd[15:0] & m);
  endfunction

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_avs_waitrequest <= 1'b1;
    end else begin
      o_avs_waitrequest <= ~(req & o_avs_waitrequest);
    end
  end

  always_comb begin
    rd16 = 16'h0000;
    unique case (idx)
      `GEDH_IDX_NUM1: rd16 = num_ff[0];
      `GEDH_IDX_NUM2: rd16 = num_ff[1];
      `GEDH_IDX_NUM3: rd16 = num_ff[2];
      `GEDH_IDX_NUM4: rd16 = num_ff[3];
      `GEDH_IDX_DEN: rd16 = den_ff;
      `GEDH_IDX_ENC_OUT: rd16 = enc_set_ff;
      `GEDH_IDX_HOME_MODE: rd16 = hmode_ff;
      `GEDH_IDX_FAST_SPD: rd16 = fast_ff;
      `GEDH_IDX_SLOW_SPD: rd16 = slow_ff;
      `GEDH_IDX_OFS_REV: rd16 = ofs_rev_ff;
      `GEDH_IDX_OFS_PULSE: rd16 = ofs_pls_ff;
      `GEDH_IDX_SCALE_SHIFT: rd16 = shift_ff;
      `GEDH_IDX_STATUS: rd16 = {11'h000, mode_bad, o_home_done, state_ff};
      default: rd16 = 16'h0000;
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_avs_readdata <= 32'h0000_0000;
    end else if (i_avs_read & o_avs_waitrequest) begin
      o_avs_readdata <= {16'h0000, rd16};
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      for (int i = 0; i < 4; i++) begin
        num_ff[i] <= `GEDH_RST_NUM;
      end
      den_ff <= `GEDH_RST_DEN;
      enc_set_ff <= `GEDH_RST_ENC_OUT;
      hmode_ff <= `GEDH_RST_HOME_MODE;
      fast_ff <= `GEDH_RST_FAST_SPD;
      slow_ff <= `GEDH_RST_SLOW_SPD;
      ofs_rev_ff <= `GEDH_RST_OFS;
      ofs_pls_ff <= `GEDH_RST_OFS;
      shift_ff <= `GEDH_RST_SHIFT;
    end else if (i_avs_write & acc_edge) begin
      unique case (idx)
        `GEDH_IDX_NUM1: num_ff[0] <= merge(num_ff[0], i_avs_writedata, wmask);
        `GEDH_IDX_NUM2: num_ff[1] <= merge(num_ff[1], i_avs_writedata, wmask);
        `GEDH_IDX_NUM3: num_ff[2] <= merge(num_ff[2], i_avs_writedata, wmask);
        `GEDH_IDX_NUM4: num_ff[3] <= merge(num_ff[3], i_avs_writedata, wmask);
        `GEDH_IDX_DEN: den_ff <= merge(den_ff, i_avs_writedata, wmask);
        `GEDH_IDX_ENC_OUT:
          enc_set_ff <= merge(enc_set_ff, i_avs_writedata, wmask);
        `GEDH_IDX_HOME_MODE:
          hmode_ff <= merge(hmode_ff, i_avs_writedata, wmask);
        `GEDH_IDX_FAST_SPD: fast_ff <= merge(fast_ff, i_avs_writedata, wmask);
        `GEDH_IDX_SLOW_SPD: slow_ff <= merge(slow_ff, i_avs_writedata, wmask);
        `GEDH_IDX_OFS_REV:
          ofs_rev_ff <= merge(ofs_rev_ff, i_avs_writedata, wmask);
        `GEDH_IDX_OFS_PULSE:
          ofs_pls_ff <= merge(ofs_pls_ff, i_avs_writedata, wmask);
        `GEDH_IDX_SCALE_SHIFT:
          shift_ff <= merge(shift_ff, i_avs_writedata, wmask);
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Electronic gear: signed remainder, at most one step out per cycle
  logic signed [ACC_W-1:0] gacc_ff, gsum, gnum, gden;

  always_comb begin
    gnum = ACC_W'($signed({1'b0, num_ff[i_gear_sel]}));
    gden = ACC_W'($signed({1'b0, den_ff}));
    gsum = gacc_ff;
    if (i_cmd_pulse) begin
      gsum = i_cmd_fwd ? gacc_ff + gnum : gacc_ff - gnum;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      gacc_ff <= '0;
      o_pos_step <= 1'b0;
      o_pos_fwd <= 1'b1;
    end else if (gden != '0 && gsum >= gden) begin
      gacc_ff <= gsum - gden;
      o_pos_step <= 1'b1;
      o_pos_fwd <= 1'b1;
    end else if (gden != '0 && gsum <= -gden) begin
      gacc_ff <= gsum + gden;
      o_pos_step <= 1'b1;
      o_pos_fwd <= 1'b0;
    end else begin
      gacc_ff <= gsum;
      o_pos_step <= 1'b0;
    end
  end

  chk_gear_step: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_pos_step && o_pos_fwd |-> $past(gsum) >= $past(gden))
    else $error("forward step without a full denominator");

  ////////////////////////////////////////////////////////////////////////////
  // Encoder emulation as a rate accumulator: add per input, spend threshold
  localparam int unsigned MIN_CYC = `GEDH_ENC_MIN_CYC;
  logic enc_direct;
  logic [15:0] enc_a;
  logic [3:0] enc_sh;
  logic [31:0] e_add, e_thr, eacc_ff, esum;
  logic [PEND_W-1:0] pend_ff;
  logic [7:0] gap_ff;
  logic e_emit, e_take;

  always_comb begin
    enc_direct = enc_set_ff >= `GEDH_ENC_DIRECT_BASE;
    enc_a = enc_direct ? enc_set_ff - `GEDH_ENC_DIRECT_BASE : enc_set_ff;
    enc_sh = shift_ff[3:0];
    if (enc_direct) begin
      e_add = 32'(enc_a) * `GEDH_ENC_SCALE_NUM;
      e_thr = `GEDH_ENC_LINES << enc_sh;
    end else begin
      e_add = `GEDH_ENC_SCALE_NUM;
      e_thr = 32'(enc_a) << enc_sh;
    end
    esum = i_enc_pulse ? eacc_ff + e_add : eacc_ff;
    e_take = e_thr != 32'h0 && enc_a != 16'h0 && esum >= e_thr
             && pend_ff != '1;
    e_emit = pend_ff != '0 && gap_ff == 8'h00;
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      eacc_ff <= 32'h0;
      pend_ff <= '0;
    end else begin
      eacc_ff <= e_take ? esum - e_thr : esum;
      pend_ff <= pend_ff + PEND_W'(e_take) - PEND_W'(e_emit);
    end
  end

  // Output paced to the rate limit; excess is queued, then held in the accumulator when full
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      gap_ff <= 8'h00;
      o_enc_out_pulse <= 1'b0;
    end else begin
      o_enc_out_pulse <= e_emit;
      if (e_emit) begin
        gap_ff <= 8'(MIN_CYC - 1);
      end else if (gap_ff != 8'h00) begin
        gap_ff <= gap_ff - 8'h01;
      end
    end
  end

  logic [7:0] since_ff;
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      since_ff <= 8'hFF;
    end else if (o_enc_out_pulse) begin
      since_ff <= 8'h01;
    end else if (since_ff != 8'hFF) begin
      since_ff <= since_ff + 8'h01;
    end
  end

  chk_enc_spacing: assert property (@(posedge i_core_clk) disable iff (i_rst)
    o_enc_out_pulse |-> since_ff >= 8'(MIN_CYC))
    else $error("encoder output pulses closer than rate limit");

  ////////////////////////////////////////////////////////////////////////////
  // Homing mode decoded from decimal digits
  logic [3:0] a_code, b_code, c_code, d_code;
  logic search_fwd, ref_hit, z_is_ref, ret_hit, start_rise;
  logic start_d_ff, pwr_pend_ff, start_req;
  logic [31:0] off_cnt_ff;
  logic off_neg;
  logic signed [31:0] ofs_total;
  logic nxt_fwd;
  logic [15:0] nxt_spd;

  always_comb begin
    a_code = 4'(hmode_ff % 16'd10);
    b_code = 4'((hmode_ff / 16'd10) % 16'd10);
    c_code = 4'((hmode_ff / 16'd100) % 16'd10);
    d_code = 4'((hmode_ff / 16'd1000) % 16'd10);
    mode_bad = a_code > 4'h5 || b_code > 4'h2 || c_code > 4'h2
               || d_code > 4'h1 || hmode_ff > 16'd9999
               || (b_code == 4'h2 && a_code < 4'h2);
    search_fwd = ~a_code[0];
    z_is_ref = a_code >= 4'h4;
    unique case (a_code)
      4'h0: ref_hit = i_fwd_limit;
      4'h1: ref_hit = i_rev_limit;
      4'h2, 4'h3: ref_hit = i_origin;
      default: ref_hit = i_zmark;
    endcase
    ret_hit = (!z_is_ref && b_code == 4'h2) ? i_origin : i_zmark;
    start_rise = i_start_homing & ~start_d_ff;
    start_req = !mode_bad && ((c_code == 4'h1 && pwr_pend_ff)
                || (c_code == 4'h2 && start_rise));
    ofs_total = 32'($signed(ofs_rev_ff)) * `GEDH_OFS_PER_REV
                + 32'($signed(ofs_pls_ff));
    off_neg = ofs_total[31];
  end

  // Automatic start is armed once per reset, i.e. per power-up
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      pwr_pend_ff <= 1'b1;
      start_d_ff <= 1'b0;
    end else begin
      start_d_ff <= i_start_homing;
      if (state_ff != gedh_pkg::ST_IDLE) begin
        pwr_pend_ff <= 1'b0;
      end
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_fwd = o_home_fwd;
    nxt_spd = o_home_speed;
    unique case (state_ff)
      gedh_pkg::ST_IDLE, gedh_pkg::ST_DONE: begin
        if (start_req) begin
          nxt_state = gedh_pkg::ST_FAST;
          nxt_fwd = search_fwd;
          nxt_spd = fast_ff;
        end
      end
      gedh_pkg::ST_FAST, gedh_pkg::ST_ZSEEK: begin
        if (state_ff == gedh_pkg::ST_FAST && ref_hit && !z_is_ref
            && b_code != 4'h2) begin
          nxt_state = gedh_pkg::ST_ZSEEK;
          nxt_fwd = b_code == 4'h0 ? ~o_home_fwd : o_home_fwd;
          nxt_spd = slow_ff;
        end else if ((state_ff == gedh_pkg::ST_FAST && ref_hit)
                     || (state_ff == gedh_pkg::ST_ZSEEK && i_zmark)) begin
          nxt_spd = slow_ff;
          if (d_code == 4'h0) begin
            nxt_state = gedh_pkg::ST_RETURN;
            nxt_fwd = ~o_home_fwd;
          end else begin
            nxt_state = gedh_pkg::ST_OFFSET;
            nxt_fwd = ~off_neg;
          end
        end
      end
      gedh_pkg::ST_RETURN: begin
        if (ret_hit) begin
          nxt_state = gedh_pkg::ST_OFFSET;
          nxt_fwd = ~off_neg;
        end
      end
      gedh_pkg::ST_OFFSET: begin
        if (off_cnt_ff == 32'h0) begin
          nxt_state = gedh_pkg::ST_DONE;
          nxt_spd = 16'h0000;
        end
      end
      default: begin
        nxt_state = gedh_pkg::ST_IDLE;
        nxt_spd = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      state_ff <= gedh_pkg::ST_IDLE;
      o_home_fwd <= 1'b1;
      o_home_speed <= 16'h0000;
      o_home_move <= 1'b0;
      o_home_done <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      o_home_fwd <= nxt_fwd;
      o_home_speed <= nxt_spd;
      o_home_move <= nxt_state != gedh_pkg::ST_IDLE
                     && nxt_state != gedh_pkg::ST_DONE;
      o_home_done <= nxt_state == gedh_pkg::ST_DONE;
    end
  end

  // Offset distance in feedback pulses, loaded at start
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      off_cnt_ff <= 32'h0;
    end else if (state_ff != gedh_pkg::ST_OFFSET && start_req) begin
      off_cnt_ff <= off_neg ? 32'(-ofs_total) : ofs_total;
    end else if (state_ff == gedh_pkg::ST_OFFSET && i_fb_pulse
                 && off_cnt_ff != 32'h0) begin
      off_cnt_ff <= off_cnt_ff - 32'h1;
    end
  end

  chk_fast_speed: assert property (@(posedge i_core_clk) disable iff (i_rst)
    state_ff == gedh_pkg::ST_FAST |-> o_home_speed == fast_ff)
    else $error("search not at fast speed");

  chk_slow_speed: assert property (@(posedge i_core_clk) disable iff (i_rst)
    state_ff inside {gedh_pkg::ST_ZSEEK, gedh_pkg::ST_RETURN}
    |-> o_home_speed == slow_ff)
    else $error("approach not at slow speed");

  chk_search_dir: assert property (@(posedge i_core_clk) disable iff (i_rst)
    state_ff == gedh_pkg::ST_FAST |-> o_home_fwd == search_fwd)
    else $error("search direction wrong");

  chk_trigger_off: assert property (@(posedge i_core_clk) disable iff (i_rst)
    state_ff == gedh_pkg::ST_IDLE && c_code == 4'h0
    |=> state_ff == gedh_pkg::ST_IDLE && !o_home_move)
    else $error("homing started while disabled");

  chk_z_reverse: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $rose(state_ff == gedh_pkg::ST_ZSEEK) && b_code == 4'h0
    |-> o_home_fwd != $past(o_home_fwd))
    else $error("Z seek did not reverse");

  chk_stop_return: assert property (@(posedge i_core_clk) disable iff (i_rst)
    $rose(state_ff == gedh_pkg::ST_RETURN) |-> d_code == 4'h0)
    else $error("return entered with stop code one");

  chk_offset_done: assert property (@(posedge i_core_clk) disable iff (i_rst)
    state_ff == gedh_pkg::ST_OFFSET && off_cnt_ff == 32'h0
    |=> o_home_done && !o_home_move)
    else $error("offset reached but homing not done");

endmodule // gedh_top

`default_nettype wire

// ---- bench/gedh_plant.sv ----
`timescale 1ns/1ps
`default_nettype none

module gedh_plant (
  input wire logic i_core_clk,
  input wire logic i_rst,
  input wire logic i_move,
  input wire logic i_fwd,
  input wire logic [15:0] i_speed,
  output logic o_fb_pulse,
  output logic o_fwd_limit,
  output logic o_rev_limit,
  output logic o_origin,
  output logic o_zmark,
  output int o_pos
);
  int tick_ff;

  // Fast moves step every 2 cycles, slow every 8, so speeds show as travel
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      tick_ff <= 0;
      o_pos <= 0;
      o_fb_pulse <= 1'b0;
    end else begin
      o_fb_pulse <= 1'b0;
      if (!i_move) begin
        tick_ff <= 0;
      end else if (tick_ff < ((i_speed >= 16'h00C8) ? 1 : 7)) begin
        tick_ff <= tick_ff + 1;
      end else begin
        tick_ff <= 0;
        o_pos <= i_fwd ? o_pos + 1 : o_pos - 1;
        o_fb_pulse <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Switch zones are wide levels, so a slow controller cannot miss them
  assign o_zmark = (((o_pos % 50) + 50) % 50) == 25;
  assign o_origin = (o_pos >= 100) && (o_pos <= 119);
  assign o_fwd_limit = o_pos >= 300;
  assign o_rev_limit = o_pos <= -100;
endmodule // gedh_plant

`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [11:0] adr = 12'h000;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdat = 32'h00000000;
  logic [31:0] rdat;
  logic [31:0] rv;
  logic wq;
  logic cmd = 1'b0;
  logic cmd_fwd = 1'b0;
  logic enc = 1'b0;
  logic start = 1'b0;
  logic [1:0] gsel = 2'h0;
  logic step, step_fwd, enc_out, flim, rlim, org, zm, fb, mv, hfwd, done;
  logic [15:0] hspd;
  logic [15:0] fast_v = 16'h03E8;
  logic [15:0] slow_v = 16'h0032;
  int pos;
  int err_count = 0;
  int compares = 0;
  int cyc = 0;
  int seed = 10;
  int steps = 0;
  int encs = 0;
  int last_enc = -100;

  localparam logic [9:0] RIX [6] = '{10'h12E, 10'h12F, 10'h130, 10'h131,
    10'h132, 10'h000};
  localparam logic [15:0] RVAL [6] = '{16'h0001, 16'h0000, 16'h03E8,
    16'h0032, 16'h0000, 16'h0000};
  // Last case outruns the rate limit, so its pulses must queue
  localparam logic [15:0] ESET [5] = '{16'h0005, 16'h2904, 16'h2904,
    16'h2724, 16'h0001};
  localparam logic [15:0] ESH [5] = '{16'h0007, 16'h0007, 16'h0008,
    16'h0006, 16'h0007};
  // Modes 102, 1202, 205, 201, 200, 203, 220, 3; bit i of masks per case
  // Order chosen so each search finds its reference from where the last
  // one parked the load
  localparam logic [15:0] HMODE [8] = '{16'h0066, 16'h04B2, 16'h00CD,
    16'h00C9, 16'h00C8, 16'h00CB, 16'h00DC, 16'h0003};
  localparam logic [7:0] HPULSE = 8'hFE;
  localparam logic [7:0] HGO = 8'h3F;
  localparam logic [7:0] HFWD = 8'h13;

  always #25 clk = ~clk;

  gedh_top dut_u (
    .i_core_clk(clk), .i_rst(rst), .i_avs_address(adr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdat),
    .i_avs_byteenable(4'hF), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wq), .i_cmd_pulse(cmd), .i_cmd_fwd(cmd_fwd),
    .i_gear_sel(gsel), .o_pos_step(step), .o_pos_fwd(step_fwd),
    .i_enc_pulse(enc), .o_enc_out_pulse(enc_out), .i_fwd_limit(flim),
    .i_rev_limit(rlim), .i_origin(org), .i_zmark(zm),
    .i_start_homing(start), .i_fb_pulse(fb), .o_home_move(mv),
    .o_home_fwd(hfwd), .o_home_speed(hspd), .o_home_done(done)
  );

  gedh_plant plant_u (
    .i_core_clk(clk), .i_rst(rst), .i_move(mv), .i_fwd(hfwd),
    .i_speed(hspd), .o_fb_pulse(fb), .o_fwd_limit(flim),
    .o_rev_limit(rlim), .o_origin(org), .o_zmark(zm), .o_pos(pos)
  );

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Counts: %0d compares, %0d mismatches", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Request held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [9:0] ix,
                     input logic [15:0] d);
    @(posedge clk);
    adr <= {ix, 2'b00};
    wdat <= {16'h0000, d};
    rd <= ~w;
    wr <= w;
    @(posedge clk);
    while (wq !== 1'b0) @(posedge clk);
    rv = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wreg(input logic [9:0] ix, input logic [15:0] d);
    bus(1'b1, ix, d);
  endtask

  task automatic rchk(input logic [9:0] ix, input logic [15:0] exp);
    bus(1'b0, ix, 16'h0000);
    chk(rv, {16'h0000, exp});
  endtask

  task automatic pulse_enc(input int n);
    repeat (n) begin
      @(posedge clk);
      enc <= 1'b1;
      @(posedge clk);
      enc <= 1'b0;
      repeat (10) @(posedge clk);
    end
  endtask

  function automatic int enc_exp(input int set, input int sh, input int n);
    int per;
    per = (set >= 10000) ? set - 10000 : 2500 / set;
    return n * per * 128 / (2500 * (1 << sh));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc++;
    if (!rst && step) begin
      steps++;
      chk(step_fwd, cmd_fwd);
    end
    if (!rst && enc_out) begin
      chk(cyc - last_enc >= 40, 1'b1);
      encs++;
      last_enc = cyc;
    end
    if (!rst) begin
      chk(mv ? (hspd === fast_v || hspd === slow_v) : hspd === 16'h0000,
          1'b1);
    end
    if (cyc == 90000) begin
      err_count++;
      end_of_test();
    end
  end

  initial begin
    int n, m, s0, k;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rchk(RIX[i], RVAL[i]);
    end
    wreg(10'h000, 16'hA5A5);
    rchk(10'h000, 16'h0000);
    wreg(10'h132, 16'hFFFD);
    rchk(10'h132, 16'hFFFD);
    wreg(10'h132, 16'h0000);
    $display("test registers finished");
    // Ratio kept within 1/4..8 and changed only while idle
    for (int s = 0; s < 4; s++) begin
      n = 1 + ($unsigned($random(seed)) % 8);
      m = 1 + ($unsigned($random(seed)) % 4);
      wreg(10'h12D, m[15:0]);
      wreg(s == 0 ? 10'h12C : 10'h13F + s[9:0], n[15:0]);
      gsel <= s[1:0];
      cmd_fwd <= 1'($random(seed));
      s0 = steps;
      repeat (4 * m) begin
        @(posedge clk);
        cmd <= 1'b1;
        @(posedge clk);
        cmd <= 1'b0;
        @(posedge clk);
      end
      repeat (150) @(posedge clk);
      chk(steps - s0, 4 * n);
    end
    $display("test gear finished");
    for (int i = 0; i < 5; i++) begin
      k = (i == 4) ? 20 : 500;
      wreg(10'h12E, ESET[i]);
      wreg(10'h143, ESH[i]);
      s0 = encs;
      pulse_enc(k);
      repeat (1000) @(posedge clk);
      chk(encs - s0, enc_exp(ESET[i], ESH[i], k));
    end
    $display("test encoder output finished");
    fast_v = 16'h00C8 + 16'($unsigned($random(seed)) % 1801);
    slow_v = 16'h0001 + 16'($unsigned($random(seed)) % 199);
    wreg(10'h130, fast_v);
    wreg(10'h131, slow_v);
    wreg(10'h133, 16'h0005);
    for (int i = 0; i < 8; i++) begin
      wreg(10'h12F, HMODE[i]);
      if (HPULSE[i]) begin
        start <= 1'b1;
      end
      k = 0;
      while (mv !== 1'b1 && k < 20) begin
        @(posedge clk);
        k++;
      end
      chk(mv, HGO[i]);
      if (HGO[i]) begin
        chk(hfwd, HFWD[i]);
        chk(hspd, fast_v);
        k = 0;
        while (done !== 1'b1 && k < 8000) begin
          @(posedge clk);
          k++;
        end
        chk({mv, done}, 2'b01);
        if (i == 1) begin
          chk(pos, 32'd80);
        end
        if (i == 5) begin
          chk(pos, 32'd130);
        end
      end
      start <= 1'b0;
      @(posedge clk);
    end
    $display("test homing finished");
    end_of_test();
  end
endmodule // tb_top

`default_nettype wire
